// ---- iaf_accept.sv ----
// Summary of operation
// - Maskable requests blocked while enable flag is 0, considered at 1.
// - Enable flag cleared automatically on every acknowledged request.
// - Stack select 0 picks handler stack pointer, 1 picks task pointer.
// - Stack select cleared when a hardware request is acknowledged.
// - Stack select also cleared by software trap with vector 0 to 31.
// - Three-bit processor priority threshold holds levels 0 to 7.
// - A request is eligible only if its level exceeds the threshold.
// - Reserved flag bit should be written 0; its read value is undefined.
// - Seven selectable request levels compared against the threshold.
// - Sources: five external, twenty-three internal, four software.
`timescale 1ns/1ns
`default_nettype none
module iaf_accept
  import iaf_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // External request pins, asynchronous
  input wire logic [IAF_SRC_EXT-1:0] ext_req_i,
  input wire logic [IAF_SRC_EXT*IAF_LVL_W-1:0] ext_lvl_i,
  // Internal peripheral requests, same clock
  input wire logic [IAF_SRC_INT-1:0] int_req_i,
  input wire logic [IAF_SRC_INT*IAF_LVL_W-1:0] int_lvl_i,
  // Software trap from the sequencer
  input wire logic trap_i,
  input wire logic [5:0] trap_vec_i,
  // Sequencer handshake
  input wire logic ack_i,
  input wire logic ret_i,
  // Register port
  input wire logic [1:0] reg_addr_i,
  input wire logic [IAF_FLG_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [IAF_FLG_W-1:0] reg_rdata_o,
  // To sequencer
  output logic irq_o,
  output logic [IAF_SRC_W-1:0] irq_src_o,
  output logic [IAF_LVL_W-1:0] irq_lvl_o,
  output logic stack_sel_o,
  output logic mask_gate_o,
  output logic [IAF_LVL_W-1:0] cpu_level_threshold_o
);
  localparam int NSW = IAF_SRC_EXT + IAF_SRC_INT;

  logic rst_meta;
  logic rstn_sync;
  logic [IAF_SRC_EXT-1:0] ext_sync;
  logic [IAF_SRC_EXT*IAF_LVL_W-1:0] ext_lvl_sync;

  iaf_flags_t flags;
  iaf_flags_t next_flags;
  iaf_flags_t saved;
  iaf_flags_t next_saved;
  logic rsv;
  logic next_rsv;
  logic [IAF_SRC_SW-1:0] sw_pend;
  logic [IAF_SRC_SW-1:0] next_sw_pend;
  logic [IAF_FLG_W-1:0] next_rdata;
  logic next_irq;
  logic [IAF_SRC_W-1:0] next_irq_src;
  logic [IAF_LVL_W-1:0] next_irq_lvl;

  logic [IAF_SRC_N-1:0] pend;
  logic [IAF_SRC_N*IAF_LVL_W-1:0] lvls;
  iaf_req_t win;
  logic hw_ack;

  // Reset release through two flops
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rstn_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rstn_sync <= rst_meta;
    end
  end

  // Pins are asynchronous, so levels and requests are both synchronised
  iaf_sync #(
    .W(IAF_SRC_EXT)
  ) u_sync_req (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_sync),
    .d_i(ext_req_i),
    .q_o(ext_sync)
  );

  iaf_sync #(
    .W(IAF_SRC_EXT * IAF_LVL_W)
  ) u_sync_lvl (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_sync),
    .d_i(ext_lvl_i),
    .q_o(ext_lvl_sync)
  );

  // Software sources use fixed level 7 so only an CPU_LEVEL_THRESHOLD of 7 hides them
  always_comb begin
    pend = {sw_pend, int_req_i, ext_sync};
    lvls = {{IAF_SRC_SW{3'h7}}, int_lvl_i, ext_lvl_sync};
    pend[NSW-1:0] = pend[NSW-1:0] & {NSW{flags.en}};
  end

  iaf_resolver #(
    .N(IAF_SRC_N)
  ) u_res (
    .pend_i(pend),
    .lvl_i(lvls),
    .thr_i(flags.lvl),
    .win_o(win)
  );

  assign hw_ack = ack_i && irq_o && (irq_src_o < IAF_SRC_W'(NSW));

  // Flag register; hardware events take priority over software writes
  always_comb begin
    next_flags = flags;
    next_saved = saved;
    next_rsv = rsv;
    next_sw_pend = sw_pend;
    if (reg_wr_i && reg_addr_i == IAF_ADR_FLG) begin
      next_flags.en = reg_wdata_i[IAF_POS_EN];
      next_flags.sel = reg_wdata_i[IAF_POS_SEL];
      next_flags.lvl = reg_wdata_i[IAF_POS_LVL +: IAF_LVL_W];
      next_rsv = reg_wdata_i[IAF_POS_RSV];
    end
    if (ret_i) begin
      next_flags = saved;
    end
    if (ack_i && irq_o) begin
      next_saved = flags;
      next_flags.en = 1'b0;
      if (hw_ack) begin
        next_flags.sel = 1'b0;
      end else begin
        next_sw_pend[2'(irq_src_o - IAF_SRC_W'(NSW))] = 1'b0;
      end
    end
    if (trap_i && trap_vec_i <= IAF_TRAP_MAX) begin
      next_saved = flags;
      next_flags.sel = 1'b0;
    end
    // Set after the ack clear, so a new software request is never lost
    if (reg_wr_i && reg_addr_i == IAF_ADR_STAT) begin
      next_sw_pend = next_sw_pend | reg_wdata_i[IAF_SRC_SW-1:0];
    end
  end

  // Request presented to the sequencer, dropped on acknowledge
  always_comb begin
    next_irq = win.valid && !(ack_i && irq_o);
    next_irq_src = win.src;
    next_irq_lvl = win.lvl;
  end

  // Reserved bit reads back whatever was last written
  always_comb begin
    next_rdata = '0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        IAF_ADR_FLG: begin
          next_rdata[IAF_POS_EN] = flags.en;
          next_rdata[IAF_POS_SEL] = flags.sel;
          next_rdata[IAF_POS_RSV] = rsv;
          next_rdata[IAF_POS_LVL +: IAF_LVL_W] = flags.lvl;
        end
        IAF_ADR_SAVED: begin
          next_rdata[IAF_POS_EN] = saved.en;
          next_rdata[IAF_POS_SEL] = saved.sel;
          next_rdata[IAF_POS_LVL +: IAF_LVL_W] = saved.lvl;
        end
        IAF_ADR_STAT: begin
          next_rdata[IAF_SRC_SW-1:0] = sw_pend;
          next_rdata[8 +: IAF_SRC_W] = win.src;
          next_rdata[15] = win.valid;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_sync) begin
    if (!rstn_sync) begin
      flags <= '{lvl: IAF_RST_LVL, sel: IAF_RST_SEL, en: IAF_RST_EN};
      saved <= '{lvl: IAF_RST_LVL, sel: IAF_RST_SEL, en: IAF_RST_EN};
      rsv <= 1'b0;
      sw_pend <= '0;
      reg_rdata_o <= '0;
      irq_o <= 1'b0;
      irq_src_o <= '0;
      irq_lvl_o <= '0;
      stack_sel_o <= 1'b0;
      mask_gate_o <= 1'b0;
      cpu_level_threshold_o <= '0;
    end else begin
      flags <= next_flags;
      saved <= next_saved;
      rsv <= next_rsv;
      sw_pend <= next_sw_pend;
      reg_rdata_o <= next_rdata;
      irq_o <= next_irq;
      irq_src_o <= next_irq_src;
      irq_lvl_o <= next_irq_lvl;
      // 0 handler_stack_pointer, 1 task_stack_pointer
      stack_sel_o <= next_flags.sel;
      mask_gate_o <= next_flags.en;
      cpu_level_threshold_o <= next_flags.lvl;
    end
  end
endmodule : iaf_accept
`default_nettype wire

// ---- iaf_accept_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module iaf_accept_asserts
  import iaf_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic trap_i,
  input wire logic [5:0] trap_vec_i,
  input wire logic ack_i,
  input wire logic ret_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [IAF_FLG_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [IAF_FLG_W-1:0] reg_rdata_o,
  input wire logic irq_o,
  input wire logic [IAF_SRC_W-1:0] irq_src_o,
  input wire logic [IAF_LVL_W-1:0] irq_lvl_o,
  input wire logic stack_sel_o,
  input wire logic mask_gate_o,
  input wire logic [IAF_LVL_W-1:0] cpu_level_threshold_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  wire logic tk = ack_i && irq_o;
  wire logic tr = trap_i && trap_vec_i <= IAF_TRAP_MAX;
  wire logic idle = !tk && !trap_i;
  wire logic [4:0] fl = {cpu_level_threshold_o, stack_sel_o, mask_gate_o};
  logic [4:0] sv;
  // Shadow of the saved flags, taken before auto clearing
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) sv <= '0;
    else if (tk || tr) sv <= fl;
  end
  chk_mask_gate: assert property (
    $rose(irq_o) && irq_src_o < 5'h1c |-> $past(mask_gate_o))
    else $error("irq raised while masked");
  chk_ack_clear: assert property (
    tk |=> !mask_gate_o && !irq_o) else $error("ack kept enable");
  chk_hw_sel: assert property (
    tk && irq_src_o < 5'h1c |=> !stack_sel_o) else $error("hw sel");
  chk_trap_sel: assert property (
    tr |=> !stack_sel_o) else $error("trap sel");
  chk_lvl_above: assert property (
    $rose(irq_o) |-> irq_lvl_o > $past(cpu_level_threshold_o))
    else $error("level not above threshold");
  chk_ret_restore: assert property (
    ret_i && idle |=> fl == sv) else $error("ret restore");
  chk_rd_flags: assert property (
    reg_rd_i && reg_addr_i == IAF_ADR_FLG |=> reg_rdata_o[7:6] ==
    $past({stack_sel_o, mask_gate_o}) && reg_rdata_o[14:12] ==
    $past(cpu_level_threshold_o)) else $error("flag read");
  chk_wr_flags: assert property (
    reg_wr_i && reg_addr_i == IAF_ADR_FLG && idle && !ret_i |=>
    fl == $past({reg_wdata_i[14:12], reg_wdata_i[7:6]}))
    else $error("flag write");
  cover property (tk);
  cover property (ret_i && idle);
  cover property (tr);
endmodule : iaf_accept_asserts
bind iaf_accept iaf_accept_asserts chk_u (.*);
`default_nettype wire

// ---- iaf_accept_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module iaf_accept_bench;
  logic sys_clk_i = 0, rstn_i = 0, trap_i = 0, ack_i = 0, ret_i = 0;
  logic reg_wr_i = 0, reg_rd_i = 0, fire = 0;
  logic [5:0] trap_vec_i = '0;
  logic [1:0] reg_addr_i = '0;
  logic [15:0] reg_wdata_i = '0, reg_rdata_o, v;
  logic [4:0] fsrc = '0, irq_src_o;
  logic [2:0] flvl = '0, irq_lvl_o, cpu_level_threshold_o;
  logic irq_o, stack_sel_o, mask_gate_o;
  logic [27:0] rq;
  logic [83:0] lv;
  wire logic [4:0] ext_req_i = rq[4:0];
  wire logic [22:0] int_req_i = rq[27:5];
  wire logic [14:0] ext_lvl_i = lv[14:0];
  wire logic [68:0] int_lvl_i = lv[83:15];
  int errors = 0, tests_run = 0, cyc = 0;
  iaf_accept dut_u (.*);
  iaf_src_model src_u (.sys_clk_i, .fire_i(fire), .src_i(fsrc),
    .lvl_i(flvl), .ack_i, .win_i(irq_src_o), .req_o(rq), .lvl_o(lv));
  always #25 sys_clk_i = ~sys_clk_i;
  task automatic close_out;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // Run is about 80 cycles, so the 3000-cycle limit lies far above it
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      close_out();
    end
  end
  task automatic chk(input logic [15:0] s, e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    @(negedge sys_clk_i);
  endtask : wr
  task automatic rd(input logic [1:0] a);
    @(posedge sys_clk_i);
    {reg_addr_i, reg_rd_i} <= {a, 1'b1};
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    v = reg_rdata_o;
  endtask : rd
  task automatic go(input logic [2:0] m);
    @(posedge sys_clk_i);
    {trap_i, ack_i, ret_i} <= m;
    @(posedge sys_clk_i);
    {trap_i, ack_i, ret_i} <= 3'h0;
    @(negedge sys_clk_i);
  endtask : go
  task automatic fire_req(input logic [4:0] s, input logic [2:0] l);
    @(posedge sys_clk_i);
    {fsrc, flvl, fire} <= {s, l, 1'b1};
    @(posedge sys_clk_i);
    fire <= 1'b0;
    @(negedge sys_clk_i);
  endtask : fire_req
  task automatic wirq;
    for (int i = 0; i < 8 && irq_o !== 1'b1; i++) @(negedge sys_clk_i);
  endtask : wirq
  task automatic t1;
    rd(2'h0);
    chk(v & 16'h70c0, 16'h0000);
    chk(mask_gate_o, 16'h0);
    wr(2'h3, 16'hf7ff);
    rd(2'h3);
    chk(v, 16'h0000);
    $display("t1 done");
  endtask : t1
  task automatic t2;
    fire_req(5'h05, 3'h3);
    repeat (4) @(negedge sys_clk_i);
    chk(irq_o, 16'h0);
    wr(2'h0, 16'h0040);
    wirq();
    chk({irq_o, irq_src_o, irq_lvl_o}, 16'h012b);
    go(3'h2);
    chk({irq_o, mask_gate_o}, 16'h0);
    $display("t2 done");
  endtask : t2
  task automatic t3;
    wr(2'h0, 16'h20c0);
    fire_req(5'h06, 3'h2);
    repeat (4) @(negedge sys_clk_i);
    chk(irq_o, 16'h0);
    fire_req(5'h07, 3'h3);
    wirq();
    chk(irq_src_o, 16'h7);
    go(3'h2);
    chk({stack_sel_o, mask_gate_o}, 16'h0);
    rd(2'h1);
    chk(v & 16'h70c0, 16'h20c0);
    go(3'h1);
    chk(stack_sel_o, 16'h1);
    chk({cpu_level_threshold_o, mask_gate_o}, 16'h5);
    $display("t3 done");
  endtask : t3
  task automatic t4;
    fire_req(5'h00, 3'h5);
    wr(2'h0, 16'h0040);
    wirq();
    chk({irq_src_o, irq_lvl_o}, 16'h0005);
    go(3'h2);
    repeat (3) @(negedge sys_clk_i);
    wr(2'h0, 16'h0040);
    wirq();
    chk({irq_src_o, irq_lvl_o}, 16'h0032);
    go(3'h2);
    $display("t4 done");
  endtask : t4
  task automatic t5;
    for (int i = 31; i < 33; i++) begin
      wr(2'h0, 16'h0080);
      @(posedge sys_clk_i);
      trap_vec_i <= i[5:0];
      go(3'h4);
      chk(stack_sel_o, 16'(i > 31));
    end
    $display("t5 done");
  endtask : t5
  task automatic t6;
    wr(2'h2, 16'h0002);
    wirq();
    chk({irq_o, irq_src_o, irq_lvl_o}, 16'h01ef);
    rd(2'h2);
    chk(v, 16'h9d02);
    go(3'h2);
    chk({irq_o, stack_sel_o, mask_gate_o}, 16'h2);
    rd(2'h2);
    chk(v, 16'h0000);
    $display("t6 done");
  endtask : t6
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    t1();
    t2();
    t3();
    t4();
    t5();
    t6();
    close_out();
  end
endmodule : iaf_accept_bench
`default_nettype wire

// ---- iaf_pkg.sv ----
package iaf_pkg;
  localparam int IAF_LVL_W = 3;
  localparam int IAF_SRC_EXT = 5;
  localparam int IAF_SRC_INT = 23;
  localparam int IAF_SRC_SW = 4;
  localparam int IAF_SRC_N = 32;
  localparam int IAF_SRC_W = 5;
  localparam logic [5:0] IAF_TRAP_MAX = 6'h1f;
  // Flag register field positions
  localparam int IAF_POS_EN = 6;
  localparam int IAF_POS_SEL = 7;
  localparam int IAF_POS_RSV = 11;
  localparam int IAF_POS_LVL = 12;
  localparam int IAF_FLG_W = 16;
  // Register addresses on the plain port
  localparam logic [1:0] IAF_ADR_FLG = 2'h0;
  localparam logic [1:0] IAF_ADR_SAVED = 2'h1;
  localparam logic [1:0] IAF_ADR_STAT = 2'h2;
  // Reset values
  localparam logic IAF_RST_EN = 1'h0;
  localparam logic IAF_RST_SEL = 1'h0;
  localparam logic [2:0] IAF_RST_LVL = 3'h0;

  typedef struct packed {
    logic [IAF_LVL_W-1:0] lvl;
    logic sel;
    logic en;
  } iaf_flags_t;

  typedef struct packed {
    logic valid;
    logic [IAF_SRC_W-1:0] src;
    logic [IAF_LVL_W-1:0] lvl;
  } iaf_req_t;
endpackage : iaf_pkg

// ---- iaf_resolver.sv ----
`timescale 1ns/1ns
`default_nettype none
module iaf_resolver
  import iaf_pkg::*;
#(
  parameter int N = IAF_SRC_N
) (
  input wire logic [N-1:0] pend_i,
  input wire logic [N*IAF_LVL_W-1:0] lvl_i,
  input wire logic [IAF_LVL_W-1:0] thr_i,
  output iaf_req_t win_o
);
  logic [N-1:0] elig;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_elig
      // Strictly above the threshold; level 0 can never win
      assign elig[g] = pend_i[g] &&
          (lvl_i[g*IAF_LVL_W +: IAF_LVL_W] > thr_i);
    end
  endgenerate

  // Highest level wins, lower index breaks ties
  always_comb begin
    win_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (elig[i] &&
          (!win_o.valid ||
           lvl_i[i*IAF_LVL_W +: IAF_LVL_W] >= win_o.lvl)) begin
        win_o.valid = 1'b1;
        win_o.src = IAF_SRC_W'(i);
        win_o.lvl = lvl_i[i*IAF_LVL_W +: IAF_LVL_W];
      end
    end
  end
endmodule : iaf_resolver
`default_nettype wire

// ---- iaf_src_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module iaf_src_model (
  input wire logic sys_clk_i,
  input wire logic fire_i,
  input wire logic [4:0] src_i,
  input wire logic [2:0] lvl_i,
  input wire logic ack_i,
  input wire logic [4:0] win_i,
  output logic [27:0] req_o,
  output logic [83:0] lvl_o
);
  initial req_o = '0;
  initial lvl_o = '0;
  // Flag holds until taken, five pins then 23 peripherals
  always @(posedge sys_clk_i) begin
    if (fire_i) begin
      req_o[src_i] <= 1'b1;
      lvl_o[src_i*3+:3] <= lvl_i;
    end
    if (ack_i && win_i < 5'h1c) req_o[win_i] <= 1'b0;
  end
endmodule : iaf_src_model
`default_nettype wire

// ---- iaf_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module iaf_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d_i;
    next_q = meta;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= next_meta;
      q_o <= next_q;
    end
  end
endmodule : iaf_sync
`default_nettype wire
